// [include/flash_host_pkg.sv]
// Constants, command codes and carriers for the parallel flash host controller.
// Assumes a 200 MHz system clock and a byte-wide flash driven through its strobes.
package flash_host_pkg;

   // ---------------------------------------------------------------
   // Geometry
   // ---------------------------------------------------------------
   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;
   localparam int BYTE_POS_W = 7;
   localparam int SECTOR_BYTES = 128;
   localparam int POLL_BIT = 7;
   localparam int TOGGLE_BIT = 6;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_PS = 5000;
   localparam int STROBE_LOW_NS = 50;
   localparam int STROBE_HIGH_NS = 50;
   localparam int LOAD_GAP_MAX_US = 150;
   localparam int CYCLE_MAX_MS = 10;
   localparam int STROBE_LOW_CYC = (STROBE_LOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int STROBE_HIGH_CYC = (STROBE_HIGH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int READ_WAIT_NS = 100;
   localparam int READ_WAIT_CYC = (READ_WAIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int LOAD_GAP_CYC = (LOAD_GAP_MAX_US * 1000000) / CLK_PERIOD_PS;
   // Grouped so the product stays inside 32 bits
   localparam int CYCLE_TIMEOUT_CYC = CYCLE_MAX_MS * (1000000000 / CLK_PERIOD_PS) * 2;
   localparam int TIMER_W = 24;

   // ---------------------------------------------------------------
   // Commands and carriers
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      CMD_READ = 3'b000,
      CMD_WRITE = 3'b001,
      CMD_PROGRAM = 3'b010,
      CMD_POLL = 3'b011
   } cmd_e;

   typedef struct packed {
      cmd_e cmd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
      logic last;
   } request_s;

   typedef struct packed {
      logic [DATA_W-1:0] data;
      logic timeout;
   } answer_s;

   typedef struct packed {
      logic ce_n;
      logic oe_n;
      logic we_n;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] dq_out;
      logic dq_oe;
   } pins_s;

endpackage

// [logic/strobe_timer.sv]
// Down counter used for every strobe width and wait in the host.
// Assumes the owner loads it and watches o_done.
`timescale 1ns/1ps
module strobe_timer #(
   parameter int WIDTH = 24
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_load,
   input wire logic [WIDTH-1:0] i_count,
   output logic o_done
);
   logic [WIDTH-1:0] count;
   logic [WIDTH-1:0] next_count;

   // Load wins over counting
   always_comb begin
      next_count = count;
      if (i_load) begin
         next_count = i_count;
      end else if (count != '0) begin
         next_count = count - 1'b1;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         count <= '0;
      end else begin
         count <= next_count;
      end
   end

   // No path from i_load: the owner derives its load from o_done
   assign o_done = (count == '0);
endmodule

// [logic/flash_host.sv]
// Host controller that drives a byte-wide sector flash by its strobes.
// Assumes the user issues one request at a time and holds it until ready.
`timescale 1ns/1ps
module flash_host #(
   parameter int LOAD_GAP = flash_host_pkg::LOAD_GAP_CYC,
   parameter int CYCLE_TIMEOUT = flash_host_pkg::CYCLE_TIMEOUT_CYC
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_req_valid,
   input wire flash_host_pkg::request_s i_req,
   output logic o_req_ready,
   output logic o_ans_valid,
   output flash_host_pkg::answer_s o_ans,
   output logic o_busy,
   output logic o_ce_n,
   output logic o_oe_n,
   output logic o_we_n,
   output logic [flash_host_pkg::ADDR_W-1:0] o_addr,
   output logic [flash_host_pkg::DATA_W-1:0] o_dq,
   output logic o_dq_oe,
   input wire logic [flash_host_pkg::DATA_W-1:0] i_dq
);
   import flash_host_pkg::*;

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0000,
      ST_WR_SETUP = 4'b0001,
      ST_WR_LOW = 4'b0010,
      ST_WR_HIGH = 4'b0011,
      ST_GAP = 4'b0100,
      ST_RD_LOW = 4'b0101,
      ST_RD_DONE = 4'b0110,
      ST_POLL_LOW = 4'b0111,
      ST_POLL_HIGH = 4'b1000,
      ST_ANSWER = 4'b1001
   } state_e;

   state_e state;
   state_e next_state;
   pins_s pins;
   pins_s next_pins;
   answer_s ans;
   answer_s next_ans;
   request_s cur;
   request_s next_cur;
   logic [ADDR_W-1:BYTE_POS_W] open_sector;
   logic [ADDR_W-1:BYTE_POS_W] next_open_sector;
   logic [DATA_W-1:0] last_byte;
   logic [DATA_W-1:0] next_last_byte;
   logic [DATA_W-1:0] prev_poll;
   logic [DATA_W-1:0] next_prev_poll;
   logic first_poll;
   logic next_first_poll;
   logic [TIMER_W-1:0] poll_cnt;
   logic [TIMER_W-1:0] next_poll_cnt;
   logic tmr_load;
   logic [TIMER_W-1:0] tmr_count;
   logic tmr_done;

   // ---------------------------------------------------------------
   // Shared timer for strobe widths and the load gap
   // ---------------------------------------------------------------
   strobe_timer #(
      .WIDTH(TIMER_W)
   ) u_timer (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_load(tmr_load),
      .i_count(tmr_count),
      .o_done(tmr_done)
   );

   // Sequencer: every strobe change is a registered pin update
   always_comb begin
      next_state = state;
      next_pins = pins;
      next_ans = ans;
      next_cur = cur;
      next_open_sector = open_sector;
      next_last_byte = last_byte;
      next_prev_poll = prev_poll;
      next_first_poll = first_poll;
      next_poll_cnt = poll_cnt;
      tmr_load = 1'b0;
      tmr_count = '0;
      o_req_ready = 1'b0;
      case (state)
         ST_IDLE, ST_GAP: begin
            o_req_ready = 1'b1;
            if (state == ST_GAP && tmr_done) begin
               // Silence past the gap lets the flash start its cycle
               next_state = ST_IDLE;
            end
            if (i_req_valid) begin
               next_cur = i_req;
               next_pins.addr = i_req.addr;
               next_pins.dq_oe = 1'b0;
               case (i_req.cmd)
                  CMD_WRITE: begin
                     // Output enable high before any write strobe
                     next_pins.oe_n = 1'b1;
                     next_pins.dq_out = i_req.data;
                     next_open_sector = i_req.addr[ADDR_W-1:BYTE_POS_W];
                     next_state = ST_WR_SETUP;
                  end
                  CMD_READ: begin
                     next_pins.ce_n = 1'b0;
                     next_pins.oe_n = 1'b0;
                     tmr_load = 1'b1;
                     tmr_count = TIMER_W'(READ_WAIT_CYC);
                     next_state = ST_RD_LOW;
                  end
                  CMD_POLL: begin
                     next_pins.addr = {open_sector, cur.addr[BYTE_POS_W-1:0]};
                     next_first_poll = 1'b1;
                     next_poll_cnt = '0;
                     next_pins.ce_n = 1'b0;
                     next_pins.oe_n = 1'b0;
                     tmr_load = 1'b1;
                     tmr_count = TIMER_W'(READ_WAIT_CYC);
                     next_state = ST_POLL_LOW;
                  end
                  default: begin
                     next_state = state;
                  end
               endcase
            end
         end
         ST_WR_SETUP: begin
            // Chip select and write strobe fall together; address taken at that fall
            next_pins.ce_n = 1'b0;
            next_pins.we_n = 1'b0;
            next_pins.dq_oe = 1'b1;
            tmr_load = 1'b1;
            tmr_count = TIMER_W'(STROBE_LOW_CYC); // Well over 15 ns filter
            next_state = ST_WR_LOW;
         end
         ST_WR_LOW: begin
            if (tmr_done) begin
               // Both rise together, data still held
               next_pins.we_n = 1'b1;
               next_pins.ce_n = 1'b1;
               tmr_load = 1'b1;
               tmr_count = TIMER_W'(STROBE_HIGH_CYC);
               next_state = ST_WR_HIGH;
            end
         end
         ST_WR_HIGH: begin
            if (tmr_done) begin
               next_pins.dq_oe = 1'b0;
               next_last_byte = cur.data;
               next_ans.data = cur.data;
               next_ans.timeout = 1'b0;
               // Gap timer bounds the next fall
               tmr_load = 1'b1;
               tmr_count = cur.last ? TIMER_W'(LOAD_GAP) : TIMER_W'(LOAD_GAP - 64);
               next_state = ST_ANSWER;
            end
         end
         ST_RD_LOW: begin
            if (tmr_done) begin
               next_ans.data = i_dq;
               next_ans.timeout = 1'b0;
               next_pins.ce_n = 1'b1; // Release bus
               next_pins.oe_n = 1'b1;
               next_state = ST_RD_DONE;
            end
         end
         ST_RD_DONE: begin
            next_state = ST_ANSWER;
         end
         ST_POLL_LOW: begin
            next_poll_cnt = poll_cnt + 1'b1;
            if (tmr_done) begin
               next_pins.ce_n = 1'b1;
               next_pins.oe_n = 1'b1;
               next_prev_poll = i_dq;
               next_first_poll = 1'b0;
               tmr_load = 1'b1;
               tmr_count = TIMER_W'(STROBE_HIGH_CYC);
               // Finished when bit 7 matches the last byte written and bit 6 stopped
               if (!first_poll && i_dq[POLL_BIT] == last_byte[POLL_BIT]
                   && i_dq[TOGGLE_BIT] == prev_poll[TOGGLE_BIT]) begin
                  next_ans.data = i_dq;
                  next_ans.timeout = 1'b0;
                  next_state = ST_ANSWER;
               end else if (poll_cnt >= TIMER_W'(CYCLE_TIMEOUT)) begin
                  // Supply inhibit or lock can stall
                  next_ans.data = i_dq;
                  next_ans.timeout = 1'b1;
                  next_state = ST_ANSWER;
               end else begin
                  next_state = ST_POLL_HIGH;
               end
            end
         end
         ST_POLL_HIGH: begin
            next_poll_cnt = poll_cnt + 1'b1;
            if (tmr_done) begin
               next_pins.ce_n = 1'b0;
               next_pins.oe_n = 1'b0;
               tmr_load = 1'b1;
               tmr_count = TIMER_W'(READ_WAIT_CYC);
               next_state = ST_POLL_LOW;
            end
         end
         ST_ANSWER: begin
            // Writes keep the gap timer; reads and polls go idle
            next_state = (cur.cmd == CMD_WRITE) ? ST_GAP : ST_IDLE;
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   // Registers; pins park deselected so the flash floats its outputs
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state <= ST_IDLE;
         pins <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: '0, dq_out: '0, dq_oe: 1'b0};
         ans <= '0;
         cur <= '0;
         open_sector <= '0;
         last_byte <= '0;
         prev_poll <= '0;
         first_poll <= 1'b1;
         poll_cnt <= '0;
      end else begin
         state <= next_state;
         pins <= next_pins;
         ans <= next_ans;
         cur <= next_cur;
         open_sector <= next_open_sector;
         last_byte <= next_last_byte;
         prev_poll <= next_prev_poll;
         first_poll <= next_first_poll;
         poll_cnt <= next_poll_cnt;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign o_ce_n = pins.ce_n;
   assign o_oe_n = pins.oe_n;
   assign o_we_n = pins.we_n;
   assign o_addr = pins.addr;
   assign o_dq = pins.dq_out;
   assign o_dq_oe = pins.dq_oe;
   assign o_ans_valid = (state == ST_ANSWER);
   assign o_ans = ans;
   assign o_busy = (state != ST_IDLE) && (state != ST_GAP);
endmodule

// [tb/flash_host_monitor.sv]
// Checker for the flash strobe pins of flash_host.
// Assumes a bind onto flash_host and a single clock domain.
`timescale 1ns/1ps
module flash_host_monitor (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic o_req_ready,
   input wire logic o_ans_valid,
   input wire flash_host_pkg::answer_s o_ans,
   input wire logic o_ce_n,
   input wire logic o_oe_n,
   input wire logic o_we_n,
   input wire logic [flash_host_pkg::ADDR_W-1:0] o_addr,
   input wire logic [flash_host_pkg::DATA_W-1:0] o_dq,
   input wire logic o_dq_oe
);
   import flash_host_pkg::*;
   // ----------------------------------------
   // Strobe relations
   // ----------------------------------------
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   chk_read_float: assert property (!o_oe_n |-> !o_dq_oe)
      else $error("host drives data in a read");
   chk_read_sel: assert property (!o_oe_n |-> o_we_n && !o_ce_n)
      else $error("read strobes wrong");
   chk_write_sel: assert property (!o_we_n |-> !o_ce_n && o_oe_n && o_dq_oe)
      else $error("write strobes wrong");
   // Filter of short pulses needs 15 ns, 8 cycles gives margin
   chk_we_width: assert property ($fell(o_we_n) |-> !o_we_n [*8])
      else $error("write pulse too short");
   chk_low_stable: assert property (!o_we_n |-> $stable(o_addr) && $stable(o_dq))
      else $error("address or data moved in pulse");
   chk_rise_data: assert property ($rose(o_we_n) |-> o_dq_oe && $stable(o_dq))
      else $error("data lost at rising strobe");
   chk_rise_addr: assert property ($rose(o_we_n) |-> $stable(o_addr))
      else $error("address lost at rising strobe");
   chk_ready_idle: assert property (o_req_ready |-> o_ce_n && o_we_n && o_oe_n)
      else $error("strobes active while ready");
   cover property ($fell(o_we_n));
   cover property (o_ans_valid && o_ans.timeout);
   cover property (o_ans_valid && !o_ans.timeout);
endmodule

bind flash_host flash_host_monitor flash_host_monitor_i (
   .i_clk, .i_rst_n, .o_req_ready, .o_ans_valid, .o_ans,
   .o_ce_n, .o_oe_n, .o_we_n, .o_addr, .o_dq, .o_dq_oe
);

// [tb/flash_model.sv]
// Behavioural sector flash that answers the host strobes.
// Assumes i_clk paces its internal timers and the released-bus value.
`timescale 1ns/1ps
module flash_model #(
   parameter int GAP = 150,
   parameter int CYC = 2000,
   parameter int PWR = 4
) (
   input wire logic i_clk,
   input wire logic i_slow,
   input wire logic i_ce_n,
   input wire logic i_oe_n,
   input wire logic i_we_n,
   input wire logic [15:0] i_addr,
   input wire logic [7:0] i_dq,
   output logic [7:0] o_dq,
   output logic o_busy
);
   logic [7:0] mem [0:65535];
   logic [7:0] lat [0:127];
   logic [127:0] ld = '0;
   logic [15:0] a;
   logic [8:0] sec;
   logic [7:0] last = 8'h00;
   logic [7:0] rel = 8'h5a;
   logic tog = 1'b0;
   logic open = 1'b0;
   // Lock codes are not modelled, so the lock stays clear from shipment
   logic lock = 1'b0;
   int pwr = 0;
   int gap = 0;
   int cyc = 0;
   realtime t0;
   initial o_busy = 1'b0;
   wire wr = !i_ce_n && !i_we_n && i_oe_n;
   wire rd = !i_ce_n && !i_oe_n && i_we_n;
   wire [7:0] drv = o_busy ? {~last[7], tog, last[5:0]} : mem[i_addr];
   // ----------------------------------------
   // Pins and load window
   // ----------------------------------------
   // Released bus shows the inverse, so stale values never match
   assign o_dq = rd ? drv : rel;
   always @(posedge rd) if (o_busy) tog = ~tog;
   // Address on the later falling edge of the two strobes
   always @(posedge wr) begin
      a = i_addr;
      t0 = $realtime;
   end
   always @(negedge wr) begin
      if (!o_busy && pwr >= PWR && $realtime - t0 >= 15.0) begin
         lat[a[6:0]] = i_dq;
         ld[a[6:0]] = 1'b1;
         sec = a[15:7];
         last = i_dq;
         open = 1'b1;
         gap = 0;
      end
   end
   // Window close, then erase and program under the timer
   always @(posedge i_clk) begin
      if (rd) rel = ~drv;
      // Supply-up delay before any load counts
      if (pwr < PWR) pwr++;
      if (open) gap = wr ? 0 : gap + 1;
      if (open && gap >= GAP) begin
         open = 1'b0;
         o_busy = 1'b1;
         cyc = 0;
      end
      if (o_busy) cyc++;
      if (o_busy && cyc >= (i_slow ? 4 * CYC : CYC)) begin
         o_busy = 1'b0;
         // A locked part runs the timer but keeps its data
         if (!lock) begin
            for (int i = 0; i < 128; i++) begin
               mem[{sec, i[6:0]}] = ld[i] ? lat[i] : 8'($urandom);
            end
         end
         ld = '0;
      end
   end
endmodule

// [tb/tb_top.sv]
// Self-checking bench: host controller against a behavioural flash.
// Assumes the checker binds itself from its own file.
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_total++; \
   $display("BAD %0t got %h want %h", $time, g, e); end end
module tb_top;
   import flash_host_pkg::*;
   typedef struct packed {
      logic cd;
      logic ct;
      answer_s a;
   } note_s;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic req_valid = 1'b0;
   request_s req = '0;
   logic slow = 1'b0;
   logic ready, ans_valid, busy, ce_n, oe_n, we_n, dq_oe, fbusy;
   answer_s ans;
   logic [15:0] addr;
   logic [7:0] dq, dq_in;
   wire [7:0] bus = dq_oe ? dq : ~dq;
   note_s q[$];
   int err_total = 0;
   int check_count = 0;
   logic [15:0] pos [3];
   logic [7:0] val [3];
   flash_host #(.LOAD_GAP(200), .CYCLE_TIMEOUT(5000)) flash_host_i (
      .i_clk(clk), .i_rst_n(rst_n), .i_req_valid(req_valid), .i_req(req),
      .o_req_ready(ready), .o_ans_valid(ans_valid), .o_ans(ans), .o_busy(busy),
      .o_ce_n(ce_n), .o_oe_n(oe_n), .o_we_n(we_n), .o_addr(addr), .o_dq(dq),
      .o_dq_oe(dq_oe), .i_dq(dq_in));
   flash_model flash_model_i (
      .i_clk(clk), .i_slow(slow), .i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n),
      .i_addr(addr), .i_dq(bus), .o_dq(dq_in), .o_busy(fbusy));
   // ----------------------------------------
   // Drivers and checks
   // ----------------------------------------
   initial begin
      forever #2.5 clk = ~clk;
   end
   // One request, held until taken; note queued for the watcher
   task automatic send(cmd_e c, logic [15:0] a, logic [7:0] d, note_s n);
      int k;
      k = 0;
      q.push_back(n);
      @(posedge clk);
      req_valid <= 1'b1;
      req <= '{c, a, d, 1'b0};
      do begin
         @(negedge clk);
         k++;
      end while (ready !== 1'b1 && k < 20000);
      if (k >= 20000) begin
         err_total++;
         $display("BAD %0t request never taken", $time);
      end
      @(posedge clk);
      req_valid <= 1'b0;
   endtask
   // Edge bytes and one random byte, loaded out of order
   task automatic sector(logic s);
      logic [8:0] sn;
      sn = 9'($urandom);
      slow <= s;
      pos = '{{sn, 7'h7f}, {sn, 7'h00}, {sn, 7'($urandom_range(1, 126))}};
      foreach (val[i]) val[i] = 8'($urandom);
      foreach (pos[i]) send(CMD_WRITE, pos[i], val[i], '0);
      // Unused command is taken and ignored; no answer, so drop its note
      send(CMD_PROGRAM, pos[2], 8'h00, '0);
      void'(q.pop_back());
      @(negedge clk);
      `CHK({ce_n, oe_n, we_n, ready}, 4'hf)
      // Let the load window close before polling
      repeat (200) @(posedge clk);
      send(CMD_POLL, pos[2], 8'h00, '{!s, 1'b1, '{val[2], s}});
      // Poll answer first, then let a slow cycle run out before reading
      wait (q.size() == 0);
      for (int k = 0; k < 20000 && fbusy !== 1'b0; k++) @(posedge clk);
      if (fbusy !== 1'b0) begin
         err_total++;
         $display("BAD %0t flash stayed busy", $time);
      end
      foreach (pos[i]) send(CMD_READ, pos[i], 8'h00, '{1'b1, 1'b0, '{val[i], 1'b0}});
   endtask
   // Slow program cycles outlast the host's poll limit
   always @(negedge clk) begin
      note_s n;
      if (ans_valid === 1'b1) begin
         `CHK(busy, 1'b1)
         if (q.size() == 0) begin
            err_total++;
            $display("BAD %0t answer not expected", $time);
         end else begin
            n = q.pop_front();
            if (n.cd) `CHK(ans.data, n.a.data)
            if (n.ct) `CHK(ans.timeout, n.a.timeout)
         end
      end
   end
   task automatic summarize();
      $display("errors %0d checks %0d", err_total, check_count);
      if (err_total == 0 && check_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge clk);
      err_total++;
      $display("BAD %0t watchdog expired", $time);
      summarize();
   end
   initial begin
      void'($urandom(32'h4527_0a5b));
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      `CHK(we_n & ce_n & ~dq_oe, 1'b1)
      sector(1'b0);
      sector(1'b1);
      sector(1'b0);
      wait (q.size() == 0);
      repeat (5) @(posedge clk);
      summarize();
   end
endmodule
